//--- bench/spps_far_model.sv
// Far-side model: pin wires, outside levels and peripheral output functions
`timescale 1ns/1ps
module spps_far_model (
	input  wire logic [15:0]  pad_out,
	input  wire logic [15:0]  pad_oe_n,
	input  wire logic [15:0]  ext_level,
	output logic      [15:0]  pad_in,
	output logic      [63:0]  func_out,
	output logic      [123:0] remap_in
);
	// Chip driver wins where enabled, the outside device elsewhere
	assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_level);
	// Uneven patterns, so a wrong select picks a different level
	assign func_out = 64'hc3a5_1e87_96f0_2d4b;
	assign remap_in = {31{4'b0110}};
endmodule : spps_far_model

//--- bench/spps_port_bench.sv
// Register-level bench for the shared port block
`timescale 1ns/1ps
`include "spps_regs.svh"
module spps_port_bench;
	import spps_pkg::*;
	localparam logic [15:0] IMPL  = 16'h7fff;
	localparam logic [15:0] OUTFN = 16'hff0f;
	logic         mclk = 1'b0;
	logic         reset = 1'b1;
	logic [7:0]   addr = 8'h00;
	spps_word_t   wdata = 16'h0000;
	logic         wr = 1'b0;
	logic         rd = 1'b0;
	logic         cmp_one = 1'b0;
	logic [15:0]  per_active = 16'h0000;
	logic [15:0]  per_out = 16'h0000;
	logic [15:0]  ext_level = 16'h0000;
	spps_word_t   rdata;
	logic [15:0]  pad_in, pad_out, pad_oe_n, per_in;
	logic [123:0] remap_in;
	logic [63:0]  func_out;
	logic         can1_rx, can2_rx;
	logic [3:0]   remap_out;
	int           mismatches = 0;
	int           n_checks = 0;
	logic [6:0]   codes [4] = '{7'h00, 7'h01, 7'h7c, 7'h2a};
	logic [5:0]   fns [4] = '{6'd0, 6'd5, 6'd37, 6'd62};

	always #50 mclk = ~mclk;

	spps_port #(.W(16), .IMPL_MSK(IMPL), .OUTFN(OUTFN)) u_spps_port (.mclk(mclk), .reset(reset),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe_n(pad_oe_n), .per_active(per_active), .per_out(per_out), .per_in(per_in),
		.remap_in(remap_in), .cmp_one(cmp_one), .can1_rx(can1_rx), .can2_rx(can2_rx),
		.func_out(func_out), .remap_out(remap_out));
	spps_far_model u_spps_far_model (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_level(ext_level),
		.pad_in(pad_in), .func_out(func_out), .remap_in(remap_in));

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, input spps_word_t d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wreg
	// Read data stand only in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input spps_word_t e, input string nm);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(nm, e, rdata);
	endtask : rchk
	task automatic settle();
		@(posedge mclk);
		#1;
	endtask : settle
	task automatic pins(input logic [15:0] ext, input logic [15:0] act, input logic [15:0] pout);
		@(posedge mclk);
		ext_level <= ext;
		per_active <= act;
		per_out <= pout;
	endtask : pins
	function automatic logic sel_exp(input logic [6:0] c);
		return (c == 7'h00) ? 1'b0 : (c == 7'h01) ? cmp_one : remap_in[c - 7'h02];
	endfunction : sel_exp
	task automatic close_out();
		$display("checks %0d, mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	// Watchdog, far beyond the roughly 110 cycles the tests need
	initial
	begin
		#500000;
		mismatches++;
		close_out();
	end

	initial
	begin
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		settle();
		chk("oe_n reset", 16'hffff, pad_oe_n);
		rchk(`SPPS_OFF_DIR, IMPL, "dir reset");
		rchk(`SPPS_OFF_CANSEL, `SPPS_CANSEL_RST, "cansel reset");
		$display("test reset done");
		wreg(`SPPS_OFF_LAT, 16'ha5c3);
		rchk(`SPPS_OFF_LAT, 16'ha5c3 & IMPL, "lat readback");
		pins(16'h0ff0, 16'h0000, 16'h0000);
		wreg(`SPPS_OFF_PIN, 16'h1e2d);
		rchk(`SPPS_OFF_LAT, 16'h1e2d & IMPL, "pin write");
		rchk(`SPPS_OFF_PIN, 16'h0ff0 & IMPL, "pin level");
		// Fresh pin change must not be visible before two sync stages
		pins(16'hf00f, 16'h0000, 16'h0000);
		rchk(`SPPS_OFF_PIN, 16'h0ff0 & IMPL, "pin sync old");
		rchk(`SPPS_OFF_PIN, 16'hf00f & IMPL, "pin sync new");
		$display("test latch done");
		wreg(`SPPS_OFF_DIR, 16'h00ff);
		settle();
		chk("oe_n mixed", 16'h80ff, pad_oe_n);
		chk("pad_out mixed", 16'h1e00, pad_out & 16'h7f00);
		chk("per_in blocked", 16'h000f, per_in & IMPL);
		rchk(`SPPS_OFF_PIN, 16'h1e0f, "pin mixed");
		$display("test direction done");
		wreg(`SPPS_OFF_PERIEN, 16'h00ff);
		wreg(`SPPS_OFF_DIR, 16'hffff);
		pins(16'h0000, 16'h0ffa, 16'hffff);
		settle();
		chk("oe_n owned", 16'hfff5, pad_oe_n);
		chk("pad_out owned", 16'h000a, pad_out & 16'h000a);
		wreg(`SPPS_OFF_LAT, 16'h0000);
		wreg(`SPPS_OFF_DIR, 16'h0000);
		repeat (3) settle();
		chk("oe_n shared", 16'h8000, pad_oe_n);
		chk("pad_out shared", 16'h000a, pad_out & IMPL);
		chk("per_in shared", 16'h000a, per_in & IMPL);
		rchk(`SPPS_OFF_PIN, 16'h000a, "pin owned");
		wreg(8'h40, 16'hffff);
		rchk(8'h40, 16'h0000, "unmapped");
		rchk(`SPPS_OFF_DIR, 16'h0000, "dir kept");
		$display("test sharing done");
		for (int i = 0; i < 4; i++)
		begin
			wreg(`SPPS_OFF_CANSEL, {1'b0, codes[i], 1'b0, codes[3-i]});
			cmp_one <= i[0];
			settle();
			chk("can2_rx", {15'h0, sel_exp(codes[i])}, {15'h0, can2_rx});
			chk("can1_rx", {15'h0, sel_exp(codes[3-i])}, {15'h0, can1_rx});
		end
		wreg(`SPPS_OFF_CANSEL, 16'hffff);
		rchk(`SPPS_OFF_CANSEL, 16'h7f7f, "cansel fields");
		for (int i = 0; i < 4; i++)
		begin
			wreg(`SPPS_OFF_OSEL_A, {2'b11, fns[i], 2'b11, fns[3-i]});
			wreg(`SPPS_OFF_OSEL_B, {2'b11, fns[3-i], 2'b11, fns[i]});
			settle();
			chk("remap_out", {12'h0, func_out[fns[3-i]], func_out[fns[i]], func_out[fns[i]],
				func_out[fns[3-i]]}, {12'h0, remap_out});
		end
		rchk(`SPPS_OFF_OSEL_A, 16'h3e00, "osel a fields");
		rchk(`SPPS_OFF_OSEL_B, 16'h003e, "osel b fields");
		$display("test select done");
		@(posedge mclk);
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		settle();
		chk("oe_n second reset", 16'hffff, pad_oe_n);
		rchk(`SPPS_OFF_DIR, IMPL, "dir second reset");
		$display("test second reset done");
		close_out();
	end
endmodule : spps_port_bench

//--- rtl/spps_pin_if.sv
// Pin-level signal group between port register logic and the pin mux
`timescale 1ns/1ps
interface spps_pin_if #(parameter int W = 16);
	logic [W-1:0] lat;
	logic [W-1:0] dir;
	logic [W-1:0] per_drive;
	logic [W-1:0] per_out;
	logic [W-1:0] pad_in;
	logic [W-1:0] pad_out;
	logic [W-1:0] pad_oe_n;
	logic [W-1:0] per_in;
	modport ctl (output lat, output dir, output per_drive, output per_out, output pad_in,
		input pad_out, input pad_oe_n, input per_in);
	modport mux (input lat, input dir, input per_drive, input per_out, input pad_in,
		output pad_out, output pad_oe_n, output per_in);
endinterface : spps_pin_if

//--- rtl/spps_pin_mux.sv
// Per-bit ownership mux between port latch and peripheral outputs
`timescale 1ns/1ps
module spps_pin_mux #(
	parameter int W = 16
) (
	spps_pin_if.mux p
);
	import spps_pkg::*;

	// One mux per pin bit
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_comb
			begin
				if (p.per_drive[i])
				begin
					p.pad_out[i]  = p.per_out[i];
					p.pad_oe_n[i] = 1'b0;
				end
				else
				begin
					p.pad_out[i]  = p.lat[i];
					p.pad_oe_n[i] = p.dir[i];
				end
				// Peripheral hears the pad only when the port is not driving it
				p.per_in[i] = (!p.per_drive[i] && !p.dir[i]) ? 1'b0 : p.pad_in[i];
			end
		end
	endgenerate
endmodule : spps_pin_mux

//--- rtl/spps_pkg.sv
// Types shared by the shared port block
package spps_pkg;
	typedef logic [15:0] spps_word_t;
	typedef logic [6:0]  spps_sel_t;
	typedef logic [5:0]  spps_func_t;
	typedef enum logic [1:0] {SPPS_IDLE, SPPS_WRITE, SPPS_READ} spps_acc_t;
endpackage : spps_pkg

//--- rtl/spps_port.sv
// Shared parallel port with peripheral ownership and remap selects
`timescale 1ns/1ps
`include "spps_regs.svh"

// Overview of operation
// - Enabled peripheral actively driving a pin owns its output; pin stays readable.
// - Peripheral enabled but not driving leaves the pin to latch and direction.
// - Port output never loops back into a peripheral input on the same pin.
// - Direction bit one makes the pin an input, zero an output.
// - Every reset makes all pins inputs.
// - Latch register reads the stored latch; writes update it.
// - Pin register reads pin levels; writes go to the latch.
// - Unimplemented bits read zero in latch, direction and pin, and stay disabled.
// - Pins shared only with input functions stay fully under port control.
// - CAN input select holds two 7-bit source fields, one per byte.
// - Output selects hold 6-bit fields at 13:8 and 5:0; 15:14, 7:6 zero.
module spps_port #(
	parameter int              W        = 16,
	parameter logic [15:0]     IMPL_MSK = 16'hffff,
	parameter logic [15:0]     OUTFN    = 16'hffff
) (
	input  wire logic                      mclk,
	input  wire logic                      reset,
	input  wire logic [`SPPS_ADDR_W-1:0]   addr,
	input  wire spps_pkg::spps_word_t      wdata,
	input  wire logic                      wr,
	input  wire logic                      rd,
	output spps_pkg::spps_word_t           rdata,
	input  wire logic [W-1:0]              pad_in,
	output logic      [W-1:0]              pad_out,
	output logic      [W-1:0]              pad_oe_n,
	input  wire logic [W-1:0]              per_active,
	input  wire logic [W-1:0]              per_out,
	output logic      [W-1:0]              per_in,
	input  wire logic [123:0]              remap_in,
	input  wire logic                      cmp_one,
	output logic                           can1_rx,
	output logic                           can2_rx,
	input  wire logic [63:0]               func_out,
	output logic      [3:0]                remap_out
);
	import spps_pkg::*;

	localparam logic [W-1:0] IMPL = IMPL_MSK[W-1:0];
	localparam logic [W-1:0] OUTF = OUTFN[W-1:0];

	logic [W-1:0]  pin_direction_control;
	logic [W-1:0]  output_latch;
	logic [W-1:0]  per_enable;
	spps_word_t    can_receive_input_select;
	spps_word_t    output_select_pins_54_55;
	spps_word_t    output_select_pins_56_57;
	logic [W-1:0]  next_dir;
	logic [W-1:0]  next_lat;
	logic [W-1:0]  next_perien;
	spps_word_t    next_cansel;
	spps_word_t    next_osel_a;
	spps_word_t    next_osel_b;
	spps_word_t    next_rdata;
	logic [W-1:0]  pin_level_readback;
	spps_acc_t     acc;

	spps_pin_if #(.W(W)) pif ();

	// Register writes; pin register writes land in the latch
	always_comb
	begin
		next_dir    = pin_direction_control;
		next_lat    = output_latch;
		next_perien = per_enable;
		next_cansel = can_receive_input_select;
		next_osel_a = output_select_pins_54_55;
		next_osel_b = output_select_pins_56_57;
		acc         = wr ? SPPS_WRITE : (rd ? SPPS_READ : SPPS_IDLE);
		if (acc == SPPS_WRITE)
		begin
			case (addr)
				`SPPS_OFF_DIR:    next_dir    = wdata[W-1:0] | ~IMPL;
				`SPPS_OFF_LAT:    next_lat    = wdata[W-1:0] & IMPL;
				`SPPS_OFF_PIN:    next_lat    = wdata[W-1:0] & IMPL;
				`SPPS_OFF_PERIEN: next_perien = wdata[W-1:0] & IMPL;
				`SPPS_OFF_CANSEL: next_cansel = wdata & 16'h7f7f;
				`SPPS_OFF_OSEL_A: next_osel_a = wdata & 16'h3f3f;
				`SPPS_OFF_OSEL_B: next_osel_b = wdata & 16'h3f3f;
				default:          next_dir    = pin_direction_control;
			endcase
		end
		if (reset)
		begin
			next_dir    = '1;
			next_lat    = '0;
			next_perien = '0;
			next_cansel = `SPPS_CANSEL_RST;
			next_osel_a = `SPPS_OSEL_RST;
			next_osel_b = `SPPS_OSEL_RST;
		end
	end

	always_ff @(posedge mclk)
	begin
		pin_direction_control    <= next_dir;
		output_latch             <= next_lat;
		per_enable               <= next_perien;
		can_receive_input_select <= next_cansel;
		output_select_pins_54_55 <= next_osel_a;
		output_select_pins_56_57 <= next_osel_b;
	end

	// Read data one cycle after a read strobe without a write, zero otherwise
	always_comb
	begin
		next_rdata = '0;
		if (acc == SPPS_READ)
		begin
			case (addr)
				`SPPS_OFF_DIR:    next_rdata[W-1:0] = pin_direction_control & IMPL;
				`SPPS_OFF_LAT:    next_rdata[W-1:0] = output_latch;
				`SPPS_OFF_PIN:    next_rdata[W-1:0] = pin_level_readback & IMPL;
				`SPPS_OFF_PERIEN: next_rdata[W-1:0] = per_enable;
				`SPPS_OFF_CANSEL: next_rdata = can_receive_input_select;
				`SPPS_OFF_OSEL_A: next_rdata = output_select_pins_54_55;
				`SPPS_OFF_OSEL_B: next_rdata = output_select_pins_56_57;
				default:          next_rdata = '0;
			endcase
		end
		if (reset)
			next_rdata = '0;
	end

	always_ff @(posedge mclk)
	begin
		rdata <= next_rdata;
	end

	// Pin levels cross into the clock domain before software sees them
	spps_sync #(.W(W)) u_sync (
		.mclk  (mclk),
		.reset (reset),
		.d     (pad_in),
		.q     (pin_level_readback)
	);

	// Ownership: only output-capable functions that are enabled and driving take over
	always_comb
	begin
		pif.lat       = output_latch;
		pif.dir       = pin_direction_control | ~IMPL;
		pif.per_drive = per_enable & per_active & OUTF & IMPL;
		pif.per_out   = per_out;
		pif.pad_in    = pad_in & IMPL;
	end

	spps_pin_mux #(.W(W)) u_mux (
		.p (pif.mux)
	);

	// Missing bits never drive
	always_comb
	begin
		pad_out  = pif.pad_out & IMPL;
		pad_oe_n = pif.pad_oe_n | ~IMPL;
		per_in   = pif.per_in;
	end

	// Pick one remap input source for a CAN receiver
	function automatic logic pick_src(input spps_sel_t sel, input logic [123:0] rin, input logic cmp);
		logic [6:0] idx;
		idx = sel - `SPPS_RPI_BASE;
		if (sel == `SPPS_SEL_VSS)
			pick_src = 1'b0;
		else if (sel == `SPPS_SEL_CMP)
			pick_src = cmp;
		else if (idx > 7'h7b)
			pick_src = 1'b0;    // Codes past the last remap pin act as ground, never index off the end
		else
			pick_src = rin[idx];
	endfunction : pick_src

	// CAN receive routing
	always_comb
	begin
		can1_rx = pick_src(can_receive_input_select[`SPPS_CAN1_LSB +: `SPPS_SEL_W], remap_in, cmp_one);
		can2_rx = pick_src(can_receive_input_select[`SPPS_CAN2_LSB +: `SPPS_SEL_W], remap_in, cmp_one);
	end

	// Remapped outputs 54..57, each takes the function output its field selects, function 0 included
	always_comb
	begin
		remap_out[0] = func_out[output_select_pins_54_55[`SPPS_OLO_LSB +: `SPPS_FUNC_W]];
		remap_out[1] = func_out[output_select_pins_54_55[`SPPS_OHI_LSB +: `SPPS_FUNC_W]];
		remap_out[2] = func_out[output_select_pins_56_57[`SPPS_OLO_LSB +: `SPPS_FUNC_W]];
		remap_out[3] = func_out[output_select_pins_56_57[`SPPS_OHI_LSB +: `SPPS_FUNC_W]];
	end

	// Checks
	chk_reset_inputs: assert property (@(posedge mclk) reset |=> pin_direction_control == '1)
		else $error("direction not all input after reset");
	chk_per_owns: assert property (@(posedge mclk) disable iff (reset)
		((pad_oe_n & per_enable & per_active & OUTF & IMPL) == '0) &&
		(((pad_out ^ per_out) & per_enable & per_active & OUTF & IMPL) == '0))
		else $error("peripheral did not own pins");
	chk_port_owns: assert property (@(posedge mclk) disable iff (reset)
		per_enable == '0 |-> pad_oe_n == (pin_direction_control | ~IMPL))
		else $error("port direction not applied");
	chk_dir_input: assert property (@(posedge mclk) disable iff (reset)
		(per_enable == '0 && pin_direction_control == '1) |-> pad_oe_n == '1)
		else $error("input pin is driven");
	chk_lat_read: assert property (@(posedge mclk) disable iff (reset)
		rd && addr == `SPPS_OFF_LAT |=> rdata[W-1:0] == $past(output_latch))
		else $error("latch readback wrong");
	chk_pin_write: assert property (@(posedge mclk) disable iff (reset)
		wr && addr == `SPPS_OFF_PIN |=> output_latch == ($past(wdata[W-1:0]) & IMPL))
		else $error("pin write missed latch");
	chk_pin_sync: assert property (@(posedge mclk) disable iff (reset)
		rd && addr == `SPPS_OFF_PIN ##0 $past(reset, 2) == 1'b0 && $past(reset) == 1'b0
		|=> rdata[W-1:0] == ($past(pad_in, 3) & IMPL))
		else $error("pin read not two flops late");
	chk_osel_zero: assert property (@(posedge mclk) disable iff (reset)
		rd && addr == `SPPS_OFF_OSEL_A |=> rdata[15:14] == 2'b00 && rdata[7:6] == 2'b00)
		else $error("reserved output select bits set");
	chk_can_field: assert property (@(posedge mclk) disable iff (reset)
		can_receive_input_select[6:0] == `SPPS_SEL_VSS |-> !can1_rx)
		else $error("grounded CAN input not low");
	chk_no_loop: assert property (@(posedge mclk) disable iff (reset)
		(per_in & ~pad_oe_n & ~(per_enable & per_active & OUTF)) == '0)
		else $error("port output looped into peripheral");

	cov_pin_write: cover property (@(posedge mclk) wr && addr == `SPPS_OFF_PIN);
	cov_per_take: cover property (@(posedge mclk) (per_enable & per_active) != '0);
	cov_can_cmp: cover property (@(posedge mclk) can_receive_input_select[6:0] == `SPPS_SEL_CMP);
endmodule : spps_port

//--- rtl/spps_regs.svh
// Register offsets, field positions and reset values of the shared port block
`ifndef SPPS_REGS_SVH
`define SPPS_REGS_SVH

`define SPPS_ADDR_W        8
`define SPPS_OFF_DIR       8'h00
`define SPPS_OFF_LAT       8'h04
`define SPPS_OFF_PIN       8'h08
`define SPPS_OFF_CANSEL    8'h0c
`define SPPS_OFF_OSEL_A    8'h10
`define SPPS_OFF_OSEL_B    8'h14
`define SPPS_OFF_PERIEN    8'h18
`define SPPS_CAN1_LSB      0
`define SPPS_CAN2_LSB      8
`define SPPS_SEL_W         7
`define SPPS_FUNC_W        6
`define SPPS_OLO_LSB       0
`define SPPS_OHI_LSB       8
`define SPPS_CANSEL_RST    16'h0000
`define SPPS_OSEL_RST      16'h0000
`define SPPS_SEL_VSS       7'h00
`define SPPS_SEL_CMP       7'h01
`define SPPS_SEL_REMAPPABLE_INPUT_PIN_124    7'h7c
`define SPPS_RPI_BASE      7'h02

`endif

//--- rtl/spps_sync.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
module spps_sync #(
	parameter int W = 16
) (
	input  wire logic         mclk,
	input  wire logic         reset,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	// Pass-through stages, reset to zero
	always_comb
	begin
		next_meta = reset ? '0 : d;
		next_q    = reset ? '0 : meta;
	end

	always_ff @(posedge mclk)
	begin
		meta <= next_meta;
		q    <= next_q;
	end
endmodule : spps_sync
